/* rtl/wcsm_top.v */
// Waveform capture serial master: config register, word sequencer, serial shifter
// Operation
// - Port off after reset; enable bit controls it
// - Enable ignored unless register interface uses I2C
// - 24-bit words sign-extended; sixteen words maximum
// - Full set sent in fixed phase order
// - Missing variant channels sent as zero words
// - Device is master: select, data, clock out
// - Data and select pins high after reset
// - Config bit 0 picks 8 or 4 MHz
// - New bit each clock fall, MSB first
// - Config bit 1 picks 32 or 8-bit packages
// - Config bit 2 inserts seven-clock gaps
// - Config bits 4:3 pick word set
// - Waveform set: seven current/voltage words
// - Power set: nine apparent/active/reactive words
// - Config bit 5 sets select polarity
// - Config bits 7:6 reserved, no effect
// - Long transfers run every second sample cycle
// - Transfer duration matches documented timing
// - Shared pins used only in I2C mode
`include "wcsm_map.vh"

module wcsm_top #(
  parameter HAS_NEUTRAL = 1,
  parameter HAS_REACTIVE = 1
) (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire CFG_WR_I,
  input wire [7:0] CFG_WDATA_I,
  input wire CAPTURE_ENABLE_I,
  input wire I2C_MODE_I,
  input wire SAMPLE_TICK_I,
  input wire [23:0] WORD_DATA_I,
  output reg [7:0] CFG_RDATA_O,
  output reg [3:0] WORD_SEL_O,
  output reg BUSY_O,
  output reg CAPTURE_PORT_OE_O,
  output reg CAPTURE_SELECT_OUT_O,
  output reg CAPTURE_DATA_OUT_O,
  output reg CAPTURE_SERIAL_CLOCK_O
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SHIFT = 2'h1;
  localparam [1:0] ST_GAP = 2'h2;

  reg [7:0] capture_port_config;
  reg [5:0] run_cfg;
  reg [1:0] state;
  reg [4:0] bit_cnt;
  reg [3:0] word_pos;
  reg [2:0] gap_cnt;
  reg [31:0] shreg;
  reg sample_phase;

  wire sclk;
  wire fall;
  wire rise;
  wire port_active;
  wire [1:0] cfg_wset;
  wire [1:0] run_wset;
  wire run_slow;
  wire run_size8;
  wire run_gap;
  wire run_pol;
  reg cfg_long;
  wire launch;
  wire pkg_end;
  wire word_end;
  reg [3:0] last_pos;
  wire [31:0] word_ext;
  reg missing;
  reg next_select;

  // Reserved upper bits are stored for readback only
  wire [5:0] cfg_used = capture_port_config[5:0];

  // Port runs only when enabled and the shared pins are free of SPI
  assign port_active = CAPTURE_ENABLE_I & I2C_MODE_I;

  assign cfg_wset = cfg_used[`WCSM_CFG_WSET_MSB:`WCSM_CFG_WSET_LSB];
  assign run_wset = run_cfg[`WCSM_CFG_WSET_MSB:`WCSM_CFG_WSET_LSB];
  assign run_slow = run_cfg[`WCSM_CFG_CLK_SLOW_BIT];
  assign run_size8 = run_cfg[`WCSM_CFG_PKG_SIZE8_BIT];
  assign run_gap = run_cfg[`WCSM_CFG_GAP_EN_BIT];
  assign run_pol = run_cfg[`WCSM_CFG_SEL_POL_BIT];

  // Settings whose transfer exceeds one sample period
  always @* begin
    case (cfg_wset)
      `WCSM_WSET_WAVE: begin
        cfg_long = 1'b0;
      end
      `WCSM_WSET_POWER: begin
        cfg_long = cfg_used[`WCSM_CFG_GAP_EN_BIT] & cfg_used[`WCSM_CFG_PKG_SIZE8_BIT] &
                   cfg_used[`WCSM_CFG_CLK_SLOW_BIT];
      end
      default: begin
        cfg_long = cfg_used[`WCSM_CFG_CLK_SLOW_BIT];
      end
    endcase
  end

  assign launch = SAMPLE_TICK_I & port_active & (state == ST_IDLE) &
                  (~cfg_long | ~sample_phase);

  // Select turns active on the launch edge so it changes in the same cycle BUSY_O rises
  always @* begin
    next_select = ~cfg_used[`WCSM_CFG_SEL_POL_BIT];
    if (launch) begin
      next_select = cfg_used[`WCSM_CFG_SEL_POL_BIT];
    end
  end

  always @* begin
    case (run_wset)
      `WCSM_WSET_WAVE: begin
        last_pos = `WCSM_WORDS_WAVE;
      end
      `WCSM_WSET_POWER: begin
        last_pos = `WCSM_WORDS_POWER;
      end
      default: begin
        last_pos = `WCSM_WORDS_ALL;
      end
    endcase
  end

  // Without gaps the package size has no effect: one continuous stream
  assign pkg_end = run_size8 ? (bit_cnt[2:0] == 3'h7) : (bit_cnt == 5'h1F);
  assign word_end = (bit_cnt == 5'h1F);

  // Position in the chosen word set to word code
  function [3:0] word_code;
    input [1:0] wset;
    input [3:0] pos;
    begin
      case (wset)
        `WCSM_WSET_WAVE: begin
          word_code = (pos == 4'h6) ? `WCSM_W_IN : pos;
        end
        `WCSM_WSET_POWER: begin
          case (pos)
            4'h0: word_code = `WCSM_W_SA;
            4'h1: word_code = `WCSM_W_SB;
            4'h2: word_code = `WCSM_W_SC;
            default: word_code = pos + 4'h7;
          endcase
        end
        default: begin
          word_code = pos;
        end
      endcase
    end
  endfunction

  always @* begin
    missing = 1'b0;
    if (WORD_SEL_O == `WCSM_W_IN && HAS_NEUTRAL == 0) begin
      missing = 1'b1;
    end
    if (WORD_SEL_O >= `WCSM_W_QA && HAS_REACTIVE == 0) begin
      missing = 1'b1;
    end
  end

  assign word_ext = missing ? 32'h00000000 : {{8{WORD_DATA_I[23]}}, WORD_DATA_I};

  wcsm_clkgen u_clkgen (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .run_i(state != ST_IDLE),
    .slow_i(run_slow),
    .sclk_o(sclk),
    .fall_o(fall),
    .rise_o(rise)
  );

  // Configuration register; written through the register interface
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      capture_port_config <= `WCSM_CFG_RESET;
      CFG_RDATA_O <= `WCSM_CFG_RESET;
    end else begin
      if (CFG_WR_I) begin
        capture_port_config <= CFG_WDATA_I;
        CFG_RDATA_O <= CFG_WDATA_I;
      end
    end
  end

  // Alternates each sample tick so long transfers take the first of two
  always @(posedge MCLK_I) begin
    if (!RST_N_I || !port_active) begin
      sample_phase <= 1'b0;
    end else if (SAMPLE_TICK_I) begin
      sample_phase <= ~sample_phase;
    end
  end

  // Transfer sequencer
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      run_cfg <= 6'h00;
      bit_cnt <= 5'h00;
      word_pos <= 4'h0;
      gap_cnt <= 3'h0;
      shreg <= 32'h00000000;
      WORD_SEL_O <= 4'h0;
      BUSY_O <= 1'b0;
    end else if (!port_active) begin
      // Disabling aborts any transfer at once
      state <= ST_IDLE;
      bit_cnt <= 5'h00;
      word_pos <= 4'h0;
      BUSY_O <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            // Config is frozen per transfer so a write cannot tear one
            run_cfg <= cfg_used;
            state <= ST_SHIFT;
            bit_cnt <= 5'h00;
            word_pos <= 4'h0;
            WORD_SEL_O <= word_code(cfg_wset, 4'h0);
            BUSY_O <= 1'b1;
          end
        end
        ST_SHIFT: begin
          if (fall) begin
            if (bit_cnt == 5'h00) begin
              shreg <= {word_ext[30:0], 1'b0};
            end else begin
              shreg <= {shreg[30:0], 1'b0};
            end
          end
          if (rise) begin
            if (word_end && word_pos == last_pos) begin
              state <= ST_IDLE;
              BUSY_O <= 1'b0;
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
              if (word_end) begin
                word_pos <= word_pos + 4'h1;
                WORD_SEL_O <= word_code(run_wset, word_pos + 4'h1);
              end
              if (run_gap && pkg_end) begin
                state <= ST_GAP;
                gap_cnt <= `WCSM_GAP_CYCLES;
              end
            end
          end
        end
        ST_GAP: begin
          if (rise) begin
            if (gap_cnt == 3'h1) begin
              state <= ST_SHIFT;
            end else begin
              gap_cnt <= gap_cnt - 3'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers; select, data and clock pins all sit high from reset until enabled
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      CAPTURE_PORT_OE_O <= 1'b0;
      CAPTURE_SELECT_OUT_O <= 1'b1;
      CAPTURE_DATA_OUT_O <= 1'b1;
      CAPTURE_SERIAL_CLOCK_O <= 1'b1;
    end else if (!port_active) begin
      CAPTURE_PORT_OE_O <= 1'b0;
      CAPTURE_SELECT_OUT_O <= 1'b1;
      CAPTURE_DATA_OUT_O <= 1'b1;
      CAPTURE_SERIAL_CLOCK_O <= 1'b1;
    end else begin
      CAPTURE_PORT_OE_O <= 1'b1;
      if (state == ST_IDLE) begin
        CAPTURE_SELECT_OUT_O <= next_select;
        CAPTURE_SERIAL_CLOCK_O <= 1'b1;
      end else begin
        CAPTURE_SELECT_OUT_O <= run_pol;
        CAPTURE_SERIAL_CLOCK_O <= (state == ST_GAP) ? 1'b1 : sclk;
      end
      if (state == ST_SHIFT && fall) begin
        CAPTURE_DATA_OUT_O <= (bit_cnt == 5'h00) ? word_ext[31] : shreg[31];
      end
    end
  end

endmodule

/* rtl/wcsm_map.vh */
// Constants for the waveform capture serial master
`ifndef WCSM_MAP_VH
`define WCSM_MAP_VH

// Capture port configuration register fields
`define WCSM_CFG_RESET 8'h00
`define WCSM_CFG_CLK_SLOW_BIT 0
`define WCSM_CFG_PKG_SIZE8_BIT 1
`define WCSM_CFG_GAP_EN_BIT 2
`define WCSM_CFG_WSET_LSB 3
`define WCSM_CFG_WSET_MSB 4
`define WCSM_CFG_SEL_POL_BIT 5

// Word set codes
`define WCSM_WSET_ALL 2'h0
`define WCSM_WSET_WAVE 2'h1
`define WCSM_WSET_POWER 2'h2
`define WCSM_WSET_RSVD 2'h3

// Last word position per word set (word count minus one)
`define WCSM_WORDS_ALL 4'hF
`define WCSM_WORDS_WAVE 4'h6
`define WCSM_WORDS_POWER 4'h8

// Word codes in full-transfer order
`define WCSM_W_IA 4'h0
`define WCSM_W_VA 4'h1
`define WCSM_W_IB 4'h2
`define WCSM_W_VB 4'h3
`define WCSM_W_IC 4'h4
`define WCSM_W_VC 4'h5
`define WCSM_W_SA 4'h6
`define WCSM_W_IN 4'h7
`define WCSM_W_SB 4'h8
`define WCSM_W_SC 4'h9
`define WCSM_W_PA 4'hA
`define WCSM_W_PB 4'hB
`define WCSM_W_PC 4'hC
`define WCSM_W_QA 4'hD
`define WCSM_W_QB 4'hE
`define WCSM_W_QC 4'hF

// Timing: clock rates in kHz, half-period phase accumulator
`define WCSM_MCLK_KHZ 100000
`define WCSM_FAST_KHZ 8000
`define WCSM_SLOW_KHZ 4000
`define WCSM_PHASE_MOD 100
`define WCSM_STEP_FAST ((2 * `WCSM_FAST_KHZ * `WCSM_PHASE_MOD) / `WCSM_MCLK_KHZ)
`define WCSM_STEP_SLOW ((2 * `WCSM_SLOW_KHZ * `WCSM_PHASE_MOD) / `WCSM_MCLK_KHZ)
`define WCSM_GAP_CYCLES 3'h7
`define WCSM_SAMPLE_US 125

`endif

/* rtl/wcsm_clkgen.v */
// Serial clock generator with one-cycle fall and rise enables
`include "wcsm_map.vh"

module wcsm_clkgen (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire slow_i,
  output reg sclk_o,
  output reg fall_o,
  output reg rise_o
);

  localparam integer STEP_FAST_FULL = `WCSM_STEP_FAST;
  localparam integer STEP_SLOW_FULL = `WCSM_STEP_SLOW;
  localparam integer MOD_FULL = `WCSM_PHASE_MOD;
  // Cut to eight bits on purpose: steps and modulus stay below 256
  localparam [7:0] STEP_FAST = STEP_FAST_FULL[7:0];
  localparam [7:0] STEP_SLOW = STEP_SLOW_FULL[7:0];
  localparam [7:0] MOD = MOD_FULL[7:0];

  reg [7:0] acc;
  wire [7:0] sum;

  // 8 MHz is not a whole divisor of the system clock, so a fractional
  // accumulator keeps the average rate exact at the price of 1-cycle jitter
  assign sum = acc + (slow_i ? STEP_SLOW : STEP_FAST);

  always @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      acc <= 8'h00;
      sclk_o <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else if (sum >= MOD) begin
      acc <= sum - MOD;
      sclk_o <= ~sclk_o;
      fall_o <= sclk_o;
      rise_o <= ~sclk_o;
    end else begin
      acc <= sum;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end
  end

endmodule

/* tb/wcsm_properties.sv */
// Port checker for the capture serial master
module wcsm_properties (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire CAPTURE_ENABLE_I,
  input wire I2C_MODE_I,
  input wire SAMPLE_TICK_I,
  input wire [7:0] CFG_RDATA_O,
  input wire BUSY_O,
  input wire CAPTURE_PORT_OE_O,
  input wire CAPTURE_SELECT_OUT_O,
  input wire CAPTURE_DATA_OUT_O,
  input wire CAPTURE_SERIAL_CLOCK_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  wire sck = CAPTURE_SERIAL_CLOCK_O;
  wire sel = CAPTURE_SELECT_OUT_O;
  rst_pins_a: assert property ($rose(RST_N_I) |-> sel && CAPTURE_DATA_OUT_O && !CAPTURE_PORT_OE_O)
    else $error("pins wrong after reset");
  idle_clk_a: assert property (!BUSY_O |-> sck) else $error("clock low while idle");
  spi_off_a: assert property (!I2C_MODE_I |=> !CAPTURE_PORT_OE_O && !BUSY_O) else $error("runs in spi mode");
  dis_off_a: assert property (!CAPTURE_ENABLE_I |=> !BUSY_O && sel && CAPTURE_DATA_OUT_O)
    else $error("runs while disabled");
  tick_launch_a: assert property ($rose(BUSY_O) |-> $past(SAMPLE_TICK_I)) else $error("launch without tick");
  sel_launch_a: assert property ($rose(BUSY_O) |-> sel == CFG_RDATA_O[5]) else $error("select level wrong");
  sel_hold_a: assert property (BUSY_O && $past(BUSY_O) |-> $stable(sel)) else $error("select moved");
  data_fall_a: assert property (BUSY_O && $past(BUSY_O) && $changed(CAPTURE_DATA_OUT_O) |-> $fell(sck))
    else $error("data moved off clock fall");
  low_half_a: assert property ($fell(sck) |-> (!sck)[*6] or ##[1:6] !BUSY_O) else $error("clock low too short");
  cover property ($rose(BUSY_O) && sel);
  cover property ($fell(BUSY_O) && !CAPTURE_ENABLE_I);
  cover property ($fell(sck) && CFG_RDATA_O[0]);
endmodule
bind wcsm_top wcsm_properties chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CAPTURE_ENABLE_I(CAPTURE_ENABLE_I),
  .I2C_MODE_I(I2C_MODE_I), .SAMPLE_TICK_I(SAMPLE_TICK_I), .CFG_RDATA_O(CFG_RDATA_O), .BUSY_O(BUSY_O),
  .CAPTURE_PORT_OE_O(CAPTURE_PORT_OE_O), .CAPTURE_SELECT_OUT_O(CAPTURE_SELECT_OUT_O),
  .CAPTURE_DATA_OUT_O(CAPTURE_DATA_OUT_O), .CAPTURE_SERIAL_CLOCK_O(CAPTURE_SERIAL_CLOCK_O));

/* tb/wcsm_slave_model.sv */
// Receiving slave: shifts in data on serial clock rise while selected
module wcsm_slave_model (
  input wire sclk_i,
  input wire sel_i,
  input wire data_i,
  input wire act_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sreg;
  int cnt;
  logic [31:0] words[$];
  // Case equality so an unknown select never counts as selected
  always @(posedge sclk_i) begin
    if (sel_i === act_i) begin
      sreg = {sreg[30:0], data_i};
      cnt++;
      if (cnt == 32) begin
        words.push_back(sreg);
        cnt = 0;
      end
    end
  end
endmodule

/* tb/wcsm_tb_top.sv */
// Self-checking bench for the capture serial master
module wcsm_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, wr = 0, en = 0, i2c = 1, tick = 0, act = 0;
  logic [7:0] wdat = 8'h00;
  logic [23:0] mem [16];
  wire [7:0] rdata;
  wire [3:0] wsel;
  wire busy, oe, sel, sd, sck;
  wire [23:0] wdata = mem[wsel];
  int miscompares, checked;
  always #5 clk = ~clk;
  // Neutral channel absent so its slot must carry zeros
  wcsm_top #(.HAS_NEUTRAL(0), .HAS_REACTIVE(1)) dut (.MCLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(wr),
    .CFG_WDATA_I(wdat), .CAPTURE_ENABLE_I(en), .I2C_MODE_I(i2c), .SAMPLE_TICK_I(tick), .WORD_DATA_I(wdata),
    .CFG_RDATA_O(rdata), .WORD_SEL_O(wsel), .BUSY_O(busy), .CAPTURE_PORT_OE_O(oe),
    .CAPTURE_SELECT_OUT_O(sel), .CAPTURE_DATA_OUT_O(sd), .CAPTURE_SERIAL_CLOCK_O(sck));
  wcsm_slave_model slv (.sclk_i(sck), .sel_i(sel), .data_i(sd), .act_i(act));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int nwords(input logic [1:0] ws);
    return ws == 2'h1 ? 7 : ws == 2'h2 ? 9 : 16;
  endfunction
  function automatic logic [31:0] expw(input logic [1:0] ws, input int i);
    logic [3:0] c;
    c = ws == 2'h1 ? (i == 6 ? 4'h7 : 4'(i)) : ws == 2'h2 ? (i == 0 ? 4'h6 : 4'(i + 7)) : 4'(i);
    return c == 4'h7 ? 32'h0 : {{8{mem[c][23]}}, mem[c]};
  endfunction
  task automatic wr_cfg(input logic [7:0] v);
    @(negedge clk);
    wr = 1;
    wdat = v;
    @(negedge clk);
    wr = 0;
    @(negedge clk);
    chk(rdata, v);
  endtask
  task automatic pulse;
    tick = 1;
    @(negedge clk);
    tick = 0;
    @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] c);
    int n, k, t0, ens;
    n = nwords(c[4:3]);
    k = c[2] ? (c[1] ? 4 * n - 1 : n - 1) : 0;
    ens = (c[0] ? 250 : 125) * (32 * n + 7 * k);
    wr_cfg(c);
    act = c[5];
    en = 1;
    slv.words.delete();
    slv.cnt = 0;
    repeat (3) @(negedge clk);
    chk(sel, !c[5]);
    t0 = int'($time);
    pulse();
    chk({busy, oe, sel}, {2'b11, c[5]});
    k = 0;
    while (busy === 1'b1 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    k = int'($time) - t0 - ens;
    chk(k / 400, 0);
    chk(slv.words.size(), n);
    foreach (slv.words[i]) chk(slv.words[i], expw(c[4:3], i));
    // The next tick launches again only if a transfer fits one sample period
    pulse();
    chk(busy, ens <= 125000);
    en = 0;
    @(negedge clk);
  endtask
  initial begin
    void'($urandom(32'h1172));
    foreach (mem[i]) mem[i] = 24'($urandom);
    repeat (6) @(negedge clk);
    rst_n = 1;
    chk({rdata, oe, sel, sd, sck}, 12'h007);
    xfer(8'hC0);
    xfer(8'h18);
    xfer(8'h0E);
    xfer(8'h29);
    xfer(8'h10);
    xfer(8'h01);
    repeat (3) xfer(8'($urandom) & 8'hFE);
    wr_cfg(8'h00);
    i2c = 0;
    en = 1;
    pulse();
    chk({busy, oe}, 2'h0);
    i2c = 1;
    @(negedge clk);
    pulse();
    repeat (200) @(negedge clk);
    en = 0;
    repeat (2) @(negedge clk);
    chk({busy, oe, sel, sd}, 4'h3);
    close_out();
  end
  initial begin
    #1000us;
    miscompares++;
    close_out();
  end
endmodule
